// file: hdl/ivs_exc_unit.v
`timescale 1ns/10ps
`include "ivs_consts.vh"

// Summary of operation
// - Vectors are fetched high byte first at the even address; timebase FFDC lowest, ADC FFDE, keyboard FFE0.
// - Async serial port vectors are transmit FFE2, receive FFE4 and error FFE6.
// - SPI transmit vector is FFE8 and SPI receive vector is FFEA.
// - Second timer vectors are overflow FFEC, channel 1 FFEE, channel 0 FFF0, priority rising.
// - First timer vectors are overflow FFF2, channel 1 FFF4, channel 0 FFF6, above second timer.
// - Interrupt entry pushes five bytes of processor registers before servicing.
// - The upper index byte is never stacked on interrupt entry.
// - A subroutine call pushes a two-byte return address.
// - The stack pointer decrements per byte pushed and increments per byte pulled.
// - The stack pointer is 16 bits and loads 00FF on reset.
module ivs_exc_unit
(
	core_clk,
	rst,
	irqReq,
	softTrapReq,
	callReq,
	pullReq,
	irqMaskBit,
	retPc,
	regX,
	regA,
	regCcr,
	busRdData,
	busReady,
	busAddr,
	busWrData,
	busWrite,
	busRead,
	stackPtr,
	vectorOut,
	entryDone,
	callDone,
	pullData,
	pullDone,
	busy
);
	input  wire        core_clk;
	input  wire        rst;
	input  wire [15:0] irqReq;
	input  wire        softTrapReq;
	input  wire        callReq;
	input  wire        pullReq;
	input  wire        irqMaskBit;
	input  wire [15:0] retPc;
	input  wire [7:0]  regX;
	input  wire [7:0]  regA;
	input  wire [7:0]  regCcr;
	input  wire [7:0]  busRdData;
	input  wire        busReady;
	output reg  [15:0] busAddr;
	output reg  [7:0]  busWrData;
	output reg         busWrite;
	output reg         busRead;
	output reg  [15:0] stackPtr;
	output reg  [15:0] vectorOut;
	output reg         entryDone;
	output reg         callDone;
	output reg  [7:0]  pullData;
	output reg         pullDone;
	output reg         busy;

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_RESET_HI = 3'h0;
	localparam ST_RESET_LO = 3'h1;
	localparam ST_IDLE     = 3'h2;
	localparam ST_PUSH     = 3'h3;
	localparam ST_VEC_HI   = 3'h4;
	localparam ST_VEC_LO   = 3'h5;
	localparam ST_PULL     = 3'h6;

	reg  [2:0]  state;
	reg  [2:0]  slot;
	reg  [2:0]  pushLast;
	reg         isCall;
	reg  [15:0] vecAddr;
	reg  [7:0]  vecHigh;
	reg  [15:0] next_vec;
	reg         next_hit;
	wire [7:0]  frameByte;
	wire [2:0]  nextSlot;
	wire [15:0] chainVec [0:`IVS_NUM_SRC];
	wire        chainHit [0:`IVS_NUM_SRC];
	genvar      g;

	// ----------------------------------------
	// Source chain: a higher source overrides every lower one
	// ----------------------------------------
	// Chain start: nothing pending, reset vector as filler
	assign chainVec[0] = `IVS_VEC_RESET;
	assign chainHit[0] = 1'b0;

	generate
		for (g = 0; g < `IVS_NUM_SRC; g = g + 1)
		begin : g_src
			// Vector offset of this source, two bytes per entry
			localparam [31:0] SRC_OFS = g * 2;
			assign chainHit[g + 1] = chainHit[g] | irqReq[g];
			assign chainVec[g + 1] = irqReq[g] ? (`IVS_VEC_BASE + SRC_OFS[15:0])
				: chainVec[g];
		end
	endgenerate

	// ----------------------------------------
	// Request arbitration
	// ----------------------------------------
	always @*
	begin
		// Top of the chain is the highest pending source
		next_vec = chainVec[`IVS_NUM_SRC];
		// Mask blocks all 16 irqReq sources, but not the soft trap
		next_hit = chainHit[`IVS_NUM_SRC] & ~irqMaskBit;
		if (softTrapReq)
		begin
			next_hit = 1'b1;
			next_vec = `IVS_VEC_SOFT_TRAP;
		end
	end

	// Lookahead slot: the byte that the next push will carry
	assign nextSlot = slot + 3'h1;

	// Frame byte selection
	ivs_byte_sel u_sel
	(
		.slot      (nextSlot),
		.retPc     (retPc),
		.regX      (regX),
		.regA      (regA),
		.regCcr    (regCcr),
		.frameByte (frameByte)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			// Bus idle, pulses low, stack at its reset value
			state     <= ST_RESET_HI;
			stackPtr  <= `IVS_SP_RESET;
			busAddr   <= `IVS_VEC_RESET;
			busWrData <= 8'h00;
			busWrite  <= 1'b0;
			busRead   <= 1'b0;
			vectorOut <= 16'h0000;
			vecAddr   <= `IVS_VEC_RESET;
			vecHigh   <= 8'h00;
			entryDone <= 1'b0;
			callDone  <= 1'b0;
			pullData  <= 8'h00;
			pullDone  <= 1'b0;
			busy      <= 1'b1;
			slot      <= 3'h0;
			pushLast  <= 3'h0;
			isCall    <= 1'b0;
		end
		else
		begin
			// Done pulses last one cycle
			entryDone <= 1'b0;
			callDone  <= 1'b0;
			pullDone  <= 1'b0;
			case (state)
				// reset fetches its own vector first
				ST_RESET_HI:
				begin
					vecAddr <= `IVS_VEC_RESET;
					busAddr <= `IVS_VEC_RESET;
					busRead <= 1'b1;
					state   <= ST_VEC_HI;
				end
				// Takes the highest pending request
				ST_IDLE:
				begin
					busy <= 1'b0;
					if (next_hit)
					begin
						vecAddr   <= next_vec;
						isCall    <= 1'b0;
						slot      <= 3'h0;
						pushLast  <= `IVS_INT_FRAME_BYTES - 3'h1;
						busAddr   <= stackPtr;
						busWrData <= retPc[7:0];
						busWrite  <= 1'b1;
						busy      <= 1'b1;
						state     <= ST_PUSH;
					end
					else if (callReq)
					begin
						isCall    <= 1'b1;
						slot      <= 3'h0;
						pushLast  <= `IVS_CALL_BYTES - 3'h1;
						busAddr   <= stackPtr;
						busWrData <= retPc[7:0];
						busWrite  <= 1'b1;
						busy      <= 1'b1;
						state     <= ST_PUSH;
					end
					else if (pullReq)
					begin
						stackPtr <= stackPtr + 16'h0001;
						busAddr  <= stackPtr + 16'h0001;
						busRead  <= 1'b1;
						busy     <= 1'b1;
						state    <= ST_PULL;
					end
				end
				// Writes one frame byte per ready
				ST_PUSH:
				begin
					if (busReady)
					begin
						stackPtr <= stackPtr - 16'h0001;
						if (slot == pushLast)
						begin
							busWrite <= 1'b0;
							if (isCall)
							begin
								callDone <= 1'b1;
								busy     <= 1'b0;
								state    <= ST_IDLE;
							end
							else
							begin
								busAddr <= vecAddr;
								busRead <= 1'b1;
								state   <= ST_VEC_HI;
							end
						end
						else
						begin
							slot      <= nextSlot;
							busAddr   <= stackPtr - 16'h0001;
							busWrData <= frameByte;
						end
					end
				end
				// high byte at even address first
				ST_VEC_HI:
				begin
					if (busReady)
					begin
						vecHigh <= busRdData;
						busAddr <= vecAddr | 16'h0001;
						state   <= ST_VEC_LO;
					end
				end
				// Low vector byte completes the entry
				ST_VEC_LO:
				begin
					if (busReady)
					begin
						vectorOut <= {vecHigh, busRdData};
						busRead   <= 1'b0;
						entryDone <= 1'b1;
						busy      <= 1'b0;
						state     <= ST_IDLE;
					end
				end
				// Reads the byte just above the old stack top
				ST_PULL:
				begin
					if (busReady)
					begin
						pullData <= busRdData;
						busRead  <= 1'b0;
						pullDone <= 1'b1;
						busy     <= 1'b0;
						state    <= ST_IDLE;
					end
				end
				// Unused codes fall back to idle
				default:
					state <= ST_IDLE;
			endcase
		end
	end
endmodule // ivs_exc_unit

// file: include/ivs_consts.vh
`ifndef IVS_CONSTS_VH
`define IVS_CONSTS_VH

// ----------------------------------------
// Vector addresses (high byte at even address)
// ----------------------------------------
`define IVS_VEC_TIMEBASE    16'hFFDC
`define IVS_VEC_ADC         16'hFFDE
`define IVS_VEC_KEYBOARD    16'hFFE0
`define IVS_VEC_SER_TX      16'hFFE2
`define IVS_VEC_SER_RX      16'hFFE4
`define IVS_VEC_SER_ERR     16'hFFE6
`define IVS_VEC_SPI_TX      16'hFFE8
`define IVS_VEC_SPI_RX      16'hFFEA
`define IVS_VEC_T2_OVF      16'hFFEC
`define IVS_VEC_T2_CH1      16'hFFEE
`define IVS_VEC_T2_CH0      16'hFFF0
`define IVS_VEC_T1_OVF      16'hFFF2
`define IVS_VEC_T1_CH1      16'hFFF4
`define IVS_VEC_T1_CH0      16'hFFF6
`define IVS_VEC_LOOP_LOCK   16'hFFF8
`define IVS_VEC_EXT_PIN     16'hFFFA
`define IVS_VEC_SOFT_TRAP   16'hFFFC
`define IVS_VEC_RESET       16'hFFFE
// Base of the vector table and number of maskable sources
`define IVS_VEC_BASE        16'hFFDC
`define IVS_NUM_SRC         16

// ----------------------------------------
// Stack
// ----------------------------------------
`define IVS_SP_RESET        16'h00FF
`define IVS_INT_FRAME_BYTES 3'h5
`define IVS_CALL_BYTES      3'h2

// ----------------------------------------
// Source request bit positions (priority rises with index)
// ----------------------------------------
`define IVS_SRC_TIMEBASE    0
`define IVS_SRC_T1_CH0      13
`define IVS_SRC_EXT_PIN     15

`endif

// file: hdl/ivs_byte_sel.v
`timescale 1ns/10ps
`include "ivs_consts.vh"

// Picks the frame byte to push for a given slot of the entry frame
module ivs_byte_sel
(
	slot,
	retPc,
	regX,
	regA,
	regCcr,
	frameByte
);
	input  wire [2:0]  slot;
	input  wire [15:0] retPc;
	input  wire [7:0]  regX;
	input  wire [7:0]  regA;
	input  wire [7:0]  regCcr;
	output reg  [7:0]  frameByte;

	// ----------------------------------------
	// Byte order: PC low, PC high, X, A, CCR
	// ----------------------------------------
	always @*
	begin
		case (slot)
			3'h0: frameByte = retPc[7:0];
			3'h1: frameByte = retPc[15:8];
			3'h2: frameByte = regX;
			3'h3: frameByte = regA;
			3'h4: frameByte = regCcr;
			default: frameByte = 8'h00;
		endcase
	end
endmodule // ivs_byte_sel

// file: verification/ivs_exc_asserts.sv
`timescale 1ns/10ps
module ivs_exc_asserts
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [15:0] retPc,
	input wire logic [7:0]  regX,
	input wire logic        busReady,
	input wire logic [15:0] busAddr,
	input wire logic [7:0]  busWrData,
	input wire logic        busWrite,
	input wire logic        busRead,
	input wire logic [15:0] stackPtr,
	input wire logic        entryDone,
	input wire logic        callDone,
	input wire logic        pullDone,
	input wire logic        busy
);
	logic [2:0]  wrCnt;
	logic [15:0] vecAddr;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts pushes of the current operation, remembers the vector
	always @(posedge core_clk)
	begin
		if (rst || entryDone || callDone || pullDone)
			wrCnt <= 3'h0;
		else if (busWrite && busReady)
			wrCnt <= wrCnt + 3'h1;
		if (busRead && busAddr >= 16'hFFDC && !busAddr[0])
			vecAddr <= busAddr;
	end
	a_sp_reset: assert property (disable iff (1'b0) rst |=> stackPtr == 16'h00FF)
		else $error("stack pointer not reloaded");
	a_push_down: assert property (busWrite && busReady |=> stackPtr == $past(stackPtr) - 16'h0001)
		else $error("push did not decrement");
	a_push_addr: assert property (busWrite |-> busAddr == stackPtr)
		else $error("push not at stack pointer");
	a_pull_addr: assert property (busRead && busAddr < 16'hFFDC |-> busAddr == stackPtr)
		else $error("pull not pre-incremented");
	a_frame_five: assert property (entryDone && vecAddr != 16'hFFFE |-> wrCnt == 3'h5)
		else $error("entry frame not five bytes");
	a_call_two: assert property (callDone |-> wrCnt == 3'h2)
		else $error("call frame not two bytes");
	a_pc_low: assert property (busWrite && wrCnt == 3'h0 |-> busWrData == retPc[7:0])
		else $error("first push not return low byte");
	a_frame_index: assert property (busWrite && wrCnt == 3'h2 |-> busWrData == regX)
		else $error("third push not index byte");
	a_vec_pair: assert property (busRead && busReady && busAddr >= 16'hFFDC && !busAddr[0]
		|=> busRead && busAddr == ($past(busAddr) | 16'h0001))
		else $error("vector low byte not next");
	a_reset_vec: assert property ($fell(rst) |=> busRead && busAddr == 16'hFFFE)
		else $error("reset vector not fetched");
	a_bus_busy: assert property (busWrite || busRead |-> busy)
		else $error("bus strobe while idle");
	a_done_free: assert property (entryDone || callDone || pullDone |-> !busy)
		else $error("busy after completion");
	c_entry: cover property (entryDone && vecAddr != 16'hFFFE);
	c_call: cover property (callDone);
	c_pull: cover property (pullDone);
endmodule // ivs_exc_asserts
bind ivs_exc_unit ivs_exc_asserts chk
(
	.core_clk  (core_clk),
	.rst       (rst),
	.retPc     (retPc),
	.regX      (regX),
	.busReady  (busReady),
	.busAddr   (busAddr),
	.busWrData (busWrData),
	.busWrite  (busWrite),
	.busRead   (busRead),
	.stackPtr  (stackPtr),
	.entryDone (entryDone),
	.callDone  (callDone),
	.pullDone  (pullDone),
	.busy      (busy)
);

// file: verification/ivs_mem_model.sv
`timescale 1ns/10ps
module ivs_mem_model
(
	input wire logic        core_clk,
	input wire logic        slow,
	input wire logic [15:0] busAddr,
	input wire logic [7:0]  busWrData,
	input wire logic        busWrite,
	output logic [7:0]      busRdData,
	output logic            busReady
);
	logic [7:0] mem [0:65535];
	logic       phase = 1'b0;
	// Address-derived fill pattern
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end
	// Slow mode answers every other cycle; data inverted while not ready
	assign busReady = !slow || phase;
	assign busRdData = busReady ? mem[busAddr] : ~mem[busAddr];
	// Store pushed bytes
	always @(posedge core_clk)
	begin
		phase <= ~phase;
		if (busWrite && busReady)
			mem[busAddr] <= busWrData;
	end
endmodule // ivs_mem_model

// file: verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(e, a) begin expV = (e); nChecks++; if (expV !== (a)) begin errors++; \
	$display("MISMATCH t=%0t exp=%h got=%h", $time, expV, (a)); end end
module tb_top;
	logic        core_clk, rst, softTrapReq, callReq, pullReq, irqMaskBit, slow;
	logic        busReady, busWrite, busRead, entryDone, callDone, pullDone, busy;
	logic [15:0] irqReq, retPc, busAddr, stackPtr, vectorOut, expV, sp;
	logic [7:0]  regX, regA, regCcr, busRdData, busWrData, pullData;
	logic [7:0]  exp8 [7];
	logic [15:0] expQ [$];
	logic [31:0] seed = 32'h82EC;
	int          errors = 0, nChecks = 0, cycles = 0, t = 0;
	ivs_exc_unit DUT
	(
		.core_clk    (core_clk),
		.rst         (rst),
		.irqReq      (irqReq),
		.softTrapReq (softTrapReq),
		.callReq     (callReq),
		.pullReq     (pullReq),
		.irqMaskBit  (irqMaskBit),
		.retPc       (retPc),
		.regX        (regX),
		.regA        (regA),
		.regCcr      (regCcr),
		.busRdData   (busRdData),
		.busReady    (busReady),
		.busAddr     (busAddr),
		.busWrData   (busWrData),
		.busWrite    (busWrite),
		.busRead     (busRead),
		.stackPtr    (stackPtr),
		.vectorOut   (vectorOut),
		.entryDone   (entryDone),
		.callDone    (callDone),
		.pullData    (pullData),
		.pullDone    (pullDone),
		.busy        (busy)
	);
	ivs_mem_model mem
	(
		.core_clk  (core_clk),
		.slow      (slow),
		.busAddr   (busAddr),
		.busWrData (busWrData),
		.busWrite  (busWrite),
		.busRdData (busRdData),
		.busReady  (busReady)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] vec(input logic [15:0] a);
		return {a[7:0] ^ 8'hA5, a[7:0] ^ 8'hA4};
	endfunction
	task automatic stopTest();
		// Notes never answered count as a single mismatch, however many remain
		if (expQ.size() != 0)
			errors++;
		$display("checks %0d errors %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One request set, held until a completion pulse
	task automatic run(input logic [15:0] irq, input logic trap, call, pull);
		bit seen;
		seen = 1'b0;
		@(negedge core_clk);
		irqReq = irq;
		softTrapReq = trap;
		callReq = call;
		pullReq = pull;
		slow = rnd() > 32'h7FFFFFFF;
		repeat (80)
		begin
			@(posedge core_clk);
			#1;
			if (entryDone || callDone || pullDone)
			begin
				seen = 1'b1;
				break;
			end
		end
		// A request that never completes is a failure
		if (!seen)
			errors++;
		@(negedge core_clk);
		{irqReq, softTrapReq, callReq, pullReq} = '0;
		$display("test %0d done", t++);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Compares each completion against the oldest note, with timeout
	always @(posedge core_clk)
	begin
		#1;
		if (entryDone)
			`CHK(expQ.pop_front(), vectorOut)
		if (callDone)
			`CHK(expQ.pop_front(), stackPtr)
		if (pullDone)
		begin
			`CHK(expQ.pop_front(), {8'h00, pullData})
			`CHK(expQ.pop_front(), stackPtr)
		end
		// Ceiling well above the longest run of the scenarios
		if (++cycles > 5000)
		begin
			errors++;
			stopTest();
		end
	end
	initial
	begin
		{irqReq, softTrapReq, callReq, pullReq, irqMaskBit, slow} = '0;
		retPc = 16'(rnd());
		{regX, regA, regCcr} = 24'(rnd());
		rst = 1'b1;
		sp = 16'h00FF;
		expQ.push_back(vec(16'hFFFE));
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		run(16'h0000, 1'b0, 1'b0, 1'b0);
		// Call then two pulls return the address high byte first
		expQ.push_back(sp - 16'h0002);
		run(16'h0000, 1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 2; k++)
		begin
			expQ.push_back({8'h00, k ? retPc[7:0] : retPc[15:8]});
			expQ.push_back(sp - 16'h0001 + 16'(k));
			run(16'h0000, 1'b0, 1'b0, 1'b1);
		end
		// Every source with random lower ones, call and pull pending
		for (int i = 0; i < 16; i++)
		begin
			expQ.push_back(vec(16'hFFDC + 16'(2 * i)));
			run((16'h0001 << i) | (16'(rnd()) & ((16'h0001 << i) - 16'h0001)), 1'b0, 1'b1, 1'b1);
			sp -= 16'h0005;
		end
		// Masked: trap still taken, then pending sources lose to a call
		irqMaskBit = 1'b1;
		expQ.push_back(vec(16'hFFFC));
		run(16'hFFFF, 1'b1, 1'b0, 1'b0);
		sp -= 16'h0007;
		expQ.push_back(sp);
		run(16'hFFFF, 1'b0, 1'b1, 1'b0);
		// Unwind call and entry frame byte by byte
		exp8 = '{retPc[15:8], retPc[7:0], regCcr, regA, regX, retPc[15:8], retPc[7:0]};
		foreach (exp8[k])
		begin
			sp++;
			expQ.push_back({8'h00, exp8[k]});
			expQ.push_back(sp);
			run(16'h0000, 1'b0, 1'b0, 1'b1);
		end
		stopTest();
	end
endmodule // tb_top
